// ===== bench/uart_tx_status_baud_gen_test.sv
`timescale 1ns/1ps
module uart_tx_status_baud_gen_test;
  import utxsb_pkg::*;
  typedef struct packed {logic [3:0] sel; logic [7:0] k; logic [7:0] d; logic [15:0] b;} utxsb_row_s;
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        timer_out = 1'b0;
  logic [15:0] bit_cyc = 16'd8;
  logic [7:0]  reg_rdata, rx_byte, rx_cnt, cnt0;
  logic        txd, rx_enable, tx_done, rx_err;
  int          failures = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          done_cnt = 0;
  int          done_last = 0;
  int          done_prev = 0;
  int          n0;
  utxsb_row_s  rows [11] = '{'{4'h0, 8'h04, 8'h55, 16'd8}, '{4'h1, 8'h04, 8'ha3, 16'd16},
    '{4'h2, 8'h04, 8'h0f, 16'd32}, '{4'h3, 8'h04, 8'h81, 16'd64}, '{4'h4, 8'h04, 8'hc6, 16'd128},
    '{4'h5, 8'h04, 8'h3c, 16'd256}, '{4'h6, 8'h04, 8'he7, 16'd512}, '{4'h7, 8'h04, 8'h18, 16'd1024},
    '{4'h0, 8'h05, 8'hf0, 16'd10}, '{4'h0, 8'hff, 8'h96, 16'd510}, '{4'hb, 8'h04, 8'h69, 16'd16}};
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) timer_out <= ~timer_out;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (tx_done === 1'b1) begin
      done_cnt  <= done_cnt + 1;
      done_prev <= done_last;
      done_last <= cyc;
    end
  end
  utxsb_top dut_u (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .timer_out, .txd, .rx_enable, .tx_done);
  utxsb_remote_rx far_u (.sys_clk, .txd, .bit_cyc, .rx_byte, .rx_cnt, .rx_err);
  // ----
  // Bus and checking tasks
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk({24'h0, reg_rdata}, {24'h0, e});
  endtask
  task automatic cfg(input logic [3:0] s, input logic [7:0] k);
    wr(MODE_OFFSET, 8'h00);
    wr(CLKSEL_OFFSET, {4'h0, s});
    wr(DIVISOR_OFFSET, k);
    wr(MODE_OFFSET, 8'h80);
    wr(MODE_OFFSET, 8'hc0);
    repeat (4 << s[2:0]) @(posedge sys_clk);
  endtask
  task automatic wait_done(input int lim);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (tx_done !== 1'b1 && n < lim);
    chk(32'(n < lim), 32'h1);
  endtask
  task automatic close_out;
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge sys_clk);
    failures++;
    close_out;
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    chk(32'(txd), 32'h1);
    rdc(STATUS_OFFSET, STATUS_RESET);
    rdc(CLKSEL_OFFSET, 8'h00);
    rdc(DIVISOR_OFFSET, DIVISOR_RESET);
    rdc(16'hff58, UNMAPPED_READ);
    foreach (rows[i]) begin
      cfg(rows[i].sel, rows[i].k);
      bit_cyc = rows[i].b;
      cnt0 = rx_cnt;
      rdc(CLKSEL_OFFSET, {4'h0, rows[i].sel});
      rdc(DIVISOR_OFFSET, rows[i].k);
      wr(TXBUF_OFFSET, rows[i].d);
      wait_done(12 * rows[i].b + 40);
      chk({8'h00, rx_cnt - cnt0, rx_byte, 7'h00, rx_err}, {8'h00, 8'h01, rows[i].d, 8'h00});
      rdc(STATUS_OFFSET, 8'h00);
    end
    // ----
    // Back-to-back pair, refresh writes in mid-frame
    // ----
    cfg(4'h0, 8'h04);
    bit_cyc = 16'd8;
    cnt0 = rx_cnt;
    wr(TXBUF_OFFSET, 8'h5a);
    repeat (6) @(posedge sys_clk);
    rdc(STATUS_OFFSET, 8'h01);
    wr(TXBUF_OFFSET, 8'hc3);
    rdc(STATUS_OFFSET, 8'h03);
    wr(CLKSEL_OFFSET, 8'h00);
    wr(DIVISOR_OFFSET, 8'h04);
    rdc(DIVISOR_OFFSET, 8'h04);
    wait_done(120);
    wait_done(120);
    @(negedge sys_clk);
    chk(done_last - done_prev, FRAME_BITS * 8);
    chk({8'h00, rx_cnt - cnt0, rx_byte, 7'h00, rx_err}, {16'h0002, 8'hc3, 8'h00});
    rdc(STATUS_OFFSET, 8'h00);
    // ----
    // Prohibited select stalls the frame, then disable aborts it
    // ----
    cfg(4'hc, 8'h04);
    n0 = done_cnt;
    wr(TXBUF_OFFSET, 8'h99);
    repeat (200) @(posedge sys_clk);
    chk(done_cnt, n0);
    rdc(STATUS_OFFSET, 8'h01);
    wr(MODE_OFFSET, 8'h80);
    rdc(STATUS_OFFSET, 8'h00);
    chk(32'(txd), 32'h1);
    wr(MODE_OFFSET, 8'ha0);
    @(negedge sys_clk);
    chk(32'(rx_enable), 32'h1);
    wr(MODE_OFFSET, 8'h00);
    rdc(CLKSEL_OFFSET, 8'h0c);
    close_out;
  end
endmodule

// ===== bench/utxsb_remote_rx.sv
`timescale 1ns/1ps
module utxsb_remote_rx (
  input wire logic        sys_clk,  // Bench clock
  input wire logic        txd,      // Line from the block
  input wire logic [15:0] bit_cyc,  // Bit length in clocks
  output logic      [7:0] rx_byte,  // Last byte seen
  output logic      [7:0] rx_cnt,   // Frames seen
  output logic            rx_err    // Bad start or stop level
);
  // ----
  // Mid-bit sampler on the falling clock, clear of the line's launch edge
  // ----
  initial begin
    rx_byte = 8'h00;
    rx_cnt  = 8'h00;
    rx_err  = 1'b0;
  end
  always begin
    @(negedge txd);
    repeat (bit_cyc / 2) @(negedge sys_clk);
    if (txd !== 1'b0) rx_err = 1'b1;
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(negedge sys_clk);
      rx_byte[i] = txd;
    end
    repeat (bit_cyc) @(negedge sys_clk);
    if (txd !== 1'b1) rx_err = 1'b1;
    rx_cnt = rx_cnt + 8'h01;
  end
endmodule

// ===== bench/utxsb_top_asserts.sv
`timescale 1ns/1ps
module utxsb_top_asserts
  import utxsb_pkg::*;
(
  input wire logic        sys_clk,    // Clock
  input wire logic        rst_b,      // Reset
  input wire logic [15:0] reg_addr,   // Address
  input wire logic [7:0]  reg_wdata,  // Write data
  input wire logic        reg_wr,     // Write strobe
  input wire logic        reg_rd,     // Read strobe
  input wire logic [7:0]  reg_rdata,  // Read data
  input wire logic        timer_out,  // Timer level
  input wire logic        txd,        // Serial out
  input wire logic        rx_enable,  // Rx enable
  input wire logic        tx_done     // Frame done
);
  // ----
  // Shadow of the mode register, rebuilt from bus writes
  // ----
  logic [7:0] mode_q;
  wire        on_w = mode_q[POWER_BIT] & mode_q[TXEN_BIT];
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) mode_q <= MODE_RESET;
    else if (reg_wr && reg_addr == MODE_OFFSET) mode_q <= reg_wdata;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ----
  // Properties
  // ----
  property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_unmap;
    reg_rd && (reg_addr > DIVISOR_OFFSET || reg_addr == TXBUF_OFFSET) |=> reg_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_stat_off;
    reg_rd && reg_addr == STATUS_OFFSET && !on_w && !$past(on_w) |=> reg_rdata == 8'h00;
  endproperty
  a_stat_off: assert property (p_stat_off) else $error("status set while off");
  property p_stat_hi; reg_rd && reg_addr == STATUS_OFFSET |=> reg_rdata[7:2] == 6'h00; endproperty
  a_stat_hi: assert property (p_stat_hi) else $error("status upper bits set");
  property p_div_rw;
    reg_wr && reg_addr == DIVISOR_OFFSET ##2 reg_rd && reg_addr == DIVISOR_OFFSET
      |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_div_rw: assert property (p_div_rw) else $error("divisor readback wrong");
  property p_pwr_off; !mode_q[POWER_BIT] |=> txd; endproperty
  a_pwr_off: assert property (p_pwr_off) else $error("line low while off");
  property p_txen_off; !mode_q[TXEN_BIT] ##1 !mode_q[TXEN_BIT] |-> txd && !tx_done; endproperty
  a_txen_off: assert property (p_txen_off) else $error("sending while disabled");
  property p_start_len; disable iff (!rst_b || !on_w) $fell(txd) |-> !txd [*8]; endproperty
  a_start_len: assert property (p_start_len) else $error("low bit too short");
  property p_busy_idle;
    $past(reg_rd) && $past(reg_addr) == STATUS_OFFSET && !reg_rdata[SHIFT_BUSY_BIT]
      && !reg_rdata[BUF_FULL_BIT] |-> txd;
  endproperty
  a_busy_idle: assert property (p_busy_idle) else $error("line active while idle");
endmodule
bind utxsb_top utxsb_top_asserts u_chk (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .timer_out, .txd, .rx_enable, .tx_done);

// ===== src/utxsb_baud_div.sv
`timescale 1ns/1ps
module utxsb_baud_div
  import utxsb_pkg::*;
(
  input  wire logic       sys_clk,      // Peripheral clock
  input  wire logic       rst_b,        // Async reset, active low
  input  wire logic       run,          // Chain enable, powered and busy
  input  wire logic       base_tick,    // Base clock enable
  input  wire logic [7:0] divisor,      // Divisor k
  output logic            bit_tick      // One-cycle bit rate enable
);
  import utxsb_pkg::*;

  logic [7:0] cnt_q;
  logic       half_q;
  logic       wrap;

  // Compare on k-1 so refresh writes of the same value never disturb
  assign wrap = base_tick && (cnt_q >= divisor - 8'h01);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 8'h00;
    end else if (!run) begin
      cnt_q <= 8'h00;
    end else if (wrap) begin
      cnt_q <= 8'h00;
    end else if (base_tick) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      half_q <= 1'b0;
    end else if (!run) begin
      half_q <= 1'b0;
    end else if (wrap) begin
      half_q <= ~half_q;
    end
  end

  assign bit_tick = wrap & half_q;

endmodule

// ===== src/utxsb_pkg.sv
package utxsb_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] MODE_OFFSET    = 16'hff50;
  localparam logic [15:0] TXBUF_OFFSET   = 16'hff54;
  localparam logic [15:0] STATUS_OFFSET  = 16'hff55;
  localparam logic [15:0] CLKSEL_OFFSET  = 16'hff56;
  localparam logic [15:0] DIVISOR_OFFSET = 16'hff57;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          POWER_BIT      = 7;
  localparam int          TXEN_BIT       = 6;
  localparam int          RXEN_BIT       = 5;
  localparam int          BUF_FULL_BIT   = 1;
  localparam int          SHIFT_BUSY_BIT = 0;
  localparam logic [7:0]  MODE_RESET     = 8'h01;
  localparam logic [7:0]  STATUS_RESET   = 8'h00;
  localparam logic [3:0]  CLKSEL_RESET   = 4'h0;
  localparam logic [7:0]  DIVISOR_RESET  = 8'hff;
  localparam logic [7:0]  UNMAPPED_READ  = 8'h00;

  // ----------------------------------------------------------------
  // Base clock selection and timing
  // ----------------------------------------------------------------
  localparam logic [3:0]  SEL_MAX_DIV    = 4'ha;
  localparam logic [3:0]  SEL_TIMER      = 4'hb;
  localparam int          PRESCALE_W     = 10;
  localparam int          FRAME_BITS     = 10;
  localparam logic [3:0]  FRAME_LAST     = 4'h9;

endpackage

// ===== src/utxsb_prescaler.sv
`timescale 1ns/1ps
module utxsb_prescaler
  import utxsb_pkg::*;
(
  input  wire logic       sys_clk,      // Peripheral clock
  input  wire logic       rst_b,        // Async reset, active low
  input  wire logic       run,          // Chain enable, powered and busy
  input  wire logic [3:0] sel,          // Base clock select code
  input  wire logic       timer_out,    // Internal timer output level
  output logic            base_tick     // One-cycle base clock enable
);
  import utxsb_pkg::*;

  logic [PRESCALE_W-1:0] pre_q;
  logic                  tmr_q;

  // ----------------------------------------------------------------
  // Divider chain, held at zero while not running
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_q <= '0;
    end else if (!run) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // Timer output taken internally, no pin needed
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tmr_q <= 1'b0;
    end else begin
      tmr_q <= timer_out;
    end
  end

  // Code n ticks when the low n bits are all ones
  function automatic logic div_tick(input logic [PRESCALE_W-1:0] cnt, input logic [3:0] n);
    logic [PRESCALE_W-1:0] mask;
    mask = PRESCALE_W'((11'h001 << n) - 11'h001);
    return (cnt & mask) == mask;
  endfunction

  always_comb begin
    base_tick = 1'b0;
    if (run) begin
      if (sel <= SEL_MAX_DIV) begin
        base_tick = div_tick(pre_q, sel);
      end else if (sel == SEL_TIMER) begin
        base_tick = timer_out & ~tmr_q;
      end
    end
  end

endmodule

// ===== src/utxsb_top.sv
// Function
// - Status reads zero after reset, unpowered, disabled
// - Buffer flag sets on write, clears on transfer
// - Busy flag sets on transfer, clears when idle
// - Buffered byte follows previous frame without gap
// - Select codes 0..10 divide by power of two
// - Code 11 selects timer; 12..15 prohibited
// - Same-value refresh writes never disturb operation
// - Eight-bit divisor, reset all ones, divides by k
// - Bit rate is divider output halved
// - Timer output reaches selector internally
// - Power off halts clock, resets serial circuit
// - Transmit disable synchronously resets transmitter
`timescale 1ns/1ps
module utxsb_top
  import utxsb_pkg::*;
(
  input  wire logic        sys_clk,     // Peripheral clock, 125 MHz
  input  wire logic        rst_b,       // Async reset, active low
  input  wire logic [15:0] reg_addr,    // Register address
  input  wire logic [7:0]  reg_wdata,   // Write data
  input  wire logic        reg_wr,      // Write strobe
  input  wire logic        reg_rd,      // Read strobe
  output logic      [7:0]  reg_rdata,   // Read data, cycle after strobe
  input  wire logic        timer_out,   // Eight-bit timer output level
  output logic             txd,         // Serial output, idle high
  output logic             rx_enable,   // Receive enable bit of mode reg
  output logic             tx_done      // Frame-complete pulse
);
  import utxsb_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] mode_q;
  logic [3:0] clksel_q;
  logic [7:0] divisor_q;
  logic [7:0] tx_buf_q;
  logic [7:0] shift_q;
  logic       buf_full_q;
  logic       shift_busy_q;
  logic [3:0] bitcnt_q;
  logic       txd_q;
  logic       done_q;
  logic [7:0] rdata_q;

  logic power;
  logic tx_en;
  logic tx_run;
  logic base_tick;
  logic bit_tick;
  logic wr_mode;
  logic wr_buf;
  logic wr_clksel;
  logic wr_div;
  logic frame_end;
  logic load;
  logic chain_run;

  assign power     = mode_q[POWER_BIT];
  assign tx_en     = mode_q[TXEN_BIT];
  assign tx_run    = power & tx_en;
  // Chain restarts at every idle-to-busy step, so a start bit on select codes 0..10 is never cut short
  assign chain_run = power & shift_busy_q;
  assign wr_mode   = reg_wr && (reg_addr == MODE_OFFSET);
  assign wr_buf    = reg_wr && (reg_addr == TXBUF_OFFSET);
  assign wr_clksel = reg_wr && (reg_addr == CLKSEL_OFFSET);
  assign wr_div    = reg_wr && (reg_addr == DIVISOR_OFFSET);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= MODE_RESET;
    end else if (wr_mode) begin
      mode_q <= reg_wdata;
    end
  end

  // Written at any time; writing a new value while powered is unsafe
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      clksel_q <= CLKSEL_RESET;
    end else if (wr_clksel) begin
      clksel_q <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      divisor_q <= DIVISOR_RESET;
    end else if (wr_div) begin
      divisor_q <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Baud chain
  // ----------------------------------------------------------------
  utxsb_prescaler u_pre (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .run       (chain_run),
    .sel       (clksel_q),
    .timer_out (timer_out),
    .base_tick (base_tick)
  );

  utxsb_baud_div u_div (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .run       (chain_run),
    .base_tick (base_tick),
    .divisor   (divisor_q),
    .bit_tick  (bit_tick)
  );

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  assign frame_end = shift_busy_q && bit_tick && (bitcnt_q == FRAME_LAST);
  // Load on idle or straight at frame end, so no idle gap
  assign load = tx_run && buf_full_q && (!shift_busy_q || frame_end);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_buf_q <= 8'h00;
    end else if (wr_buf) begin
      tx_buf_q <= reg_wdata;
    end
  end

  // Write while full overwrites the pending byte
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      buf_full_q <= 1'b0;
    end else if (!tx_run) begin
      buf_full_q <= 1'b0;
    end else if (wr_buf) begin
      buf_full_q <= 1'b1;
    end else if (load) begin
      buf_full_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_busy_q <= 1'b0;
    end else if (!tx_run) begin
      shift_busy_q <= 1'b0;
    end else if (load) begin
      shift_busy_q <= 1'b1;
    end else if (frame_end) begin
      shift_busy_q <= 1'b0;
    end
  end

  // Frame: start, eight data bits LSB first, one stop
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_q  <= 8'h00;
      bitcnt_q <= 4'h0;
      txd_q    <= 1'b1;
    end else if (!tx_run) begin
      bitcnt_q <= 4'h0;
      txd_q    <= 1'b1;
    end else if (load) begin
      shift_q  <= tx_buf_q;
      bitcnt_q <= 4'h0;
      txd_q    <= 1'b0;
    end else if (shift_busy_q && bit_tick && !frame_end) begin
      bitcnt_q <= bitcnt_q + 4'h1;
      txd_q    <= (bitcnt_q == 4'h8) ? 1'b1 : shift_q[0];
      shift_q  <= {1'b1, shift_q[7:1]};
    end else if (frame_end) begin
      txd_q    <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      done_q <= 1'b0;
    end else begin
      done_q <= frame_end && tx_run;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        MODE_OFFSET:    rdata_q <= mode_q;
        STATUS_OFFSET:  rdata_q <= {6'h00, buf_full_q, shift_busy_q};
        CLKSEL_OFFSET:  rdata_q <= {4'h0, clksel_q};
        DIVISOR_OFFSET: rdata_q <= divisor_q;
        default:        rdata_q <= UNMAPPED_READ;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;
  assign txd       = txd_q;
  assign tx_done   = done_q;
  assign rx_enable = mode_q[RXEN_BIT];

endmodule
